// ---- rtl/cfs_core.sv ----
// cpu condition flags, stack pointer and the three pointer pairs
// assumes the execution unit drives one-cycle request strobes on clk
//
// Summary of operation
// - flags are rewritten after every alu operation with its result.
// - interrupt entry and exit never save or restore the flags.
// - bit 7 is global interrupt enable; zero blocks all interrupts.
// - taking an interrupt clears bit 7; interrupt exit sets it.
// - enable and disable ops set or clear bit 7 directly.
// - bit 6 stores one copied bit, to and from a register bit.
// - bit 5 holds the low nibble carry where the operation affects it.
// - bit 4 equals negative xor overflow after each alu operation; a flags register write can set it freely.
// - bit 3 flags signed two's complement overflow.
// - bit 2 is set when the result's top bit is one.
// - bit 1 is set on an all-zero result, cleared otherwise.
// - bit 0 captures the operation's carry.
// - the six top registers form three 16-bit data pointers.
// - pointer access supports displacement, post increment, pre decrement.
// - stack grows downward; every push lowers the pointer.
// - byte push lowers pointer by one; call or interrupt by two.
// - byte pop raises pointer by one; returns raise it by two.
// - stack pointer is two rw bytes at 0x3e and 0x3d, reset to top.
// - with an 8-bit data space only the low byte exists.
`timescale 1ns/1ps
module cfs_core #(
	parameter bit SP_HIGH_PRESENT = 1'b1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// i/o register port
	input wire logic [5:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// alu flag update
	input wire logic alu_valid,
	input wire logic [7:0] alu_result,
	input wire logic alu_carry,
	input wire logic alu_half_carry,
	input wire logic alu_half_en,
	input wire logic alu_overflow,
	// flag instructions
	input wire logic interrupt_enable_op,
	input wire logic interrupt_disable_op,
	input wire logic register_to_flag_copy,
	input wire logic copy_bit_in,
	output logic flag_to_register_copy_bit,
	// interrupt handshake
	input wire logic irq_request,
	output logic irq_take,
	// stack operations
	input wire cfs_pkg::cfs_stk_op_t stk_op,
	output logic [15:0] stk_addr,
	// pointer pair registers
	input wire logic [1:0] ptr_sel,
	input wire cfs_pkg::cfs_ptr_mode_t ptr_mode,
	input wire logic [5:0] ptr_disp,
	input wire logic ptr_load,
	input wire logic [15:0] ptr_load_value,
	output logic [15:0] ptr_addr,
	// state views
	output logic [7:0] cpu_condition_flags,
	output logic [15:0] stack_pointer
);
	////////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] flags;
		logic [15:0] sp;
		logic [2:0][15:0] ptr;
		logic [7:0] rdata;
		logic [15:0] stk_addr;
		logic [15:0] ptr_addr;
	} cfs_state_t;

	cfs_state_t st_r;
	cfs_state_t st_nxt;

	function automatic logic [15:0] sp_mask(input logic [15:0] v);
		sp_mask = SP_HIGH_PRESENT ? v : {8'h00, v[7:0]};
	endfunction : sp_mask

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic neg;
		logic ovf;
		logic [15:0] p;
		neg = 1'b0;
		ovf = 1'b0;
		p = 16'h0000;
		st_nxt = st_r;
		// interrupt acceptance gated by global enable
		if (irq_take) begin
			st_nxt.flags[cfs_pkg::FLAG_I] = 1'b0;
		end
		// alu result flags; other flags untouched, nothing saved on entry
		if (alu_valid) begin
			neg = alu_result[7];
			ovf = alu_overflow;
			st_nxt.flags[cfs_pkg::FLAG_C] = alu_carry;
			st_nxt.flags[cfs_pkg::FLAG_Z] = (alu_result == 8'h00);
			st_nxt.flags[cfs_pkg::FLAG_N] = neg;
			st_nxt.flags[cfs_pkg::FLAG_V] = ovf;
			st_nxt.flags[cfs_pkg::FLAG_S] = neg ^ ovf;
			if (alu_half_en) begin
				st_nxt.flags[cfs_pkg::FLAG_H] = alu_half_carry;
			end
		end
		if (register_to_flag_copy) begin
			st_nxt.flags[cfs_pkg::FLAG_T] = copy_bit_in;
		end
		if (interrupt_enable_op) begin
			st_nxt.flags[cfs_pkg::FLAG_I] = 1'b1;
		end
		if (interrupt_disable_op) begin
			st_nxt.flags[cfs_pkg::FLAG_I] = 1'b0;
		end
		// stack pointer moves downward on push
		st_nxt.stk_addr = st_r.sp;
		unique case (stk_op)
			cfs_pkg::STK_NONE: begin
			end
			cfs_pkg::STK_PUSH: begin
				st_nxt.sp = sp_mask(st_r.sp - 16'h0001);
			end
			cfs_pkg::STK_CALL, cfs_pkg::STK_INT: begin
				st_nxt.sp = sp_mask(st_r.sp - 16'h0002);
			end
			cfs_pkg::STK_POP: begin
				st_nxt.sp = sp_mask(st_r.sp + 16'h0001);
				st_nxt.stk_addr = sp_mask(st_r.sp + 16'h0001);
			end
			cfs_pkg::STK_RET: begin
				st_nxt.sp = sp_mask(st_r.sp + 16'h0002);
				st_nxt.stk_addr = sp_mask(st_r.sp + 16'h0001);
			end
			cfs_pkg::STK_INTERRUPT_EXIT: begin
				st_nxt.sp = sp_mask(st_r.sp + 16'h0002);
				st_nxt.stk_addr = sp_mask(st_r.sp + 16'h0001);
				st_nxt.flags[cfs_pkg::FLAG_I] = 1'b1;
			end
			default: begin
			end
		endcase
		// pointer pairs: x, y, z
		if (ptr_sel != 2'b11) begin
			p = st_r.ptr[ptr_sel];
			unique case (ptr_mode)
				cfs_pkg::PTR_NONE: begin
					st_nxt.ptr_addr = p;
				end
				cfs_pkg::PTR_DISP: begin
					st_nxt.ptr_addr = p + {10'h000, ptr_disp};
				end
				cfs_pkg::PTR_POSTINC: begin
					st_nxt.ptr_addr = p;
					st_nxt.ptr[ptr_sel] = p + 16'h0001;
				end
				cfs_pkg::PTR_PREDEC: begin
					st_nxt.ptr_addr = p - 16'h0001;
					st_nxt.ptr[ptr_sel] = p - 16'h0001;
				end
				default: begin
					st_nxt.ptr_addr = p;
				end
			endcase
			if (ptr_load) begin
				st_nxt.ptr[ptr_sel] = ptr_load_value;
			end
		end
		// register writes win over same-cycle hardware updates
		if (reg_wr) begin
			unique case (reg_addr)
				cfs_pkg::STACK_POINTER_LOW_OFS: begin
					st_nxt.sp[7:0] = reg_wdata;
				end
				cfs_pkg::STACK_POINTER_HIGH_OFS: begin
					if (SP_HIGH_PRESENT) begin
						st_nxt.sp[15:8] = reg_wdata;
					end
				end
				cfs_pkg::CPU_CONDITION_FLAGS_OFS: begin
					st_nxt.flags = reg_wdata;
				end
				default: begin
				end
			endcase
		end
		st_nxt.rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				cfs_pkg::STACK_POINTER_LOW_OFS: begin
					st_nxt.rdata = st_r.sp[7:0];
				end
				cfs_pkg::STACK_POINTER_HIGH_OFS: begin
					st_nxt.rdata = SP_HIGH_PRESENT ? st_r.sp[15:8] : 8'h00;
				end
				cfs_pkg::CPU_CONDITION_FLAGS_OFS: begin
					st_nxt.rdata = st_r.flags;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.flags <= cfs_pkg::FLAGS_RESET;
			st_r.sp <= sp_mask(cfs_pkg::TOP_OF_DATA_MEMORY);
			st_r.ptr <= {3{cfs_pkg::POINTER_RESET}};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign irq_take = irq_request & st_r.flags[cfs_pkg::FLAG_I];
	assign reg_rdata = st_r.rdata;
	assign flag_to_register_copy_bit = st_r.flags[cfs_pkg::FLAG_T];
	assign cpu_condition_flags = st_r.flags;
	assign stack_pointer = st_r.sp;
	assign stk_addr = st_r.stk_addr;
	assign ptr_addr = st_r.ptr_addr;
endmodule : cfs_core

// ---- rtl/cfs_pkg.sv ----
// package for the cpu flags and stack pointer block
// assumes a single 10 MHz cpu clock and byte-wide i/o register port
package cfs_pkg;
	// i/o register offsets
	localparam logic [5:0] STACK_POINTER_LOW_OFS = 6'h3d;
	localparam logic [5:0] STACK_POINTER_HIGH_OFS = 6'h3e;
	localparam logic [5:0] CPU_CONDITION_FLAGS_OFS = 6'h3f;
	// flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h015f;
	localparam logic [15:0] POINTER_RESET = 16'h0000;
	// stack operation codes, one-hot
	typedef enum logic [6:0] {
		STK_NONE = 7'h01,
		STK_PUSH = 7'h02,
		STK_POP = 7'h04,
		STK_CALL = 7'h08,
		STK_INT = 7'h10,
		STK_RET = 7'h20,
		STK_INTERRUPT_EXIT = 7'h40
	} cfs_stk_op_t;
	// pointer access modes, one-hot
	typedef enum logic [3:0] {
		PTR_NONE = 4'h1,
		PTR_DISP = 4'h2,
		PTR_POSTINC = 4'h4,
		PTR_PREDEC = 4'h8
	} cfs_ptr_mode_t;
endpackage : cfs_pkg

// ---- sim/cfs_checker.sv ----
// checker for the flags and stack pointer block
// assumes binding inside cfs_core by port name
`timescale 1ns/1ps
module cfs_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched ports
	input wire logic reg_wr,
	input wire logic alu_valid,
	input wire logic [7:0] alu_result,
	input wire logic alu_carry,
	input wire logic alu_overflow,
	input wire logic interrupt_enable_op,
	input wire logic irq_request,
	input wire logic irq_take,
	input wire cfs_pkg::cfs_stk_op_t stk_op,
	input wire logic [15:0] stk_addr,
	input wire logic [7:0] cpu_condition_flags,
	input wire logic [15:0] stack_pointer
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence push_s;
		stk_op == cfs_pkg::STK_PUSH && !reg_wr;
	endsequence
	alu_flags_a: assert property (
		alu_valid && !reg_wr |=> cpu_condition_flags[3:0] == {$past(alu_overflow),
		$past(alu_result[7]), $past(alu_result) == 8'h00, $past(alu_carry)}) else $error("alu flags");
	sign_bit_a: assert property (
		cpu_condition_flags[4] == (cpu_condition_flags[2] ^ cpu_condition_flags[3]))
		else $error("sign flag");
	irq_gate_a: assert property (
		irq_take == (irq_request && cpu_condition_flags[7])) else $error("irq gate");
	irq_clear_a: assert property (
		irq_take && !interrupt_enable_op && !reg_wr && stk_op != cfs_pkg::STK_INTERRUPT_EXIT
		|=> !cpu_condition_flags[7]) else $error("irq kept enable");
	interrupt_exit_set_a: assert property (
		stk_op == cfs_pkg::STK_INTERRUPT_EXIT && !reg_wr |=> cpu_condition_flags[7])
		else $error("return kept disable");
	byte_push_a: assert property (
		push_s |=> stack_pointer == $past(stack_pointer) - 16'h0001
		&& stk_addr == $past(stack_pointer)) else $error("push");
	byte_pop_a: assert property (
		stk_op == cfs_pkg::STK_POP && !reg_wr |=> stack_pointer == $past(stack_pointer)
		+ 16'h0001 && stk_addr == stack_pointer) else $error("pop");
	pair_push_a: assert property (
		(stk_op == cfs_pkg::STK_CALL || stk_op == cfs_pkg::STK_INT) && !reg_wr
		|=> stack_pointer == $past(stack_pointer) - 16'h0002) else $error("call push");
endmodule : cfs_chk
bind cfs_core cfs_chk u_chk (.*);

// ---- sim/testbench.sv ----
// bench for the flags and stack pointer block
// assumes cfs_core with both stack bytes; pointer pairs driven by t_ptr
`timescale 1ns/1ps
module testbench;
	logic clk = '0, rst = '1, reg_wr = '0, reg_rd = '0, alu_valid = '0, alu_carry = '0;
	logic alu_half_carry = '0, alu_half_en = '0, alu_overflow = '0, copy_bit_in = '0;
	logic interrupt_enable_op = '0, interrupt_disable_op = '0, register_to_flag_copy = '0;
	logic irq_request = '0, ptr_load = '0, flag_to_register_copy_bit, irq_take;
	logic [1:0] ptr_sel = '0;
	logic [5:0] reg_addr = '0, ptr_disp = '0;
	logic [7:0] reg_wdata = '0, alu_result = '0, reg_rdata, cpu_condition_flags;
	logic [15:0] ptr_load_value = '0, stk_addr, ptr_addr, stack_pointer;
	cfs_pkg::cfs_stk_op_t stk_op = cfs_pkg::STK_NONE;
	cfs_pkg::cfs_ptr_mode_t ptr_mode = cfs_pkg::PTR_NONE;
	int mismatches = 0, samples_checked = 0, cycles = 0;
	cfs_core u_dut (.*);
	////////////////////////////////////////
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// one edge, strobes back to idle, then outputs settled
	task go;
		@(posedge clk);
		reg_wr <= '0;
		reg_rd <= '0;
		alu_valid <= '0;
		interrupt_enable_op <= '0;
		interrupt_disable_op <= '0;
		register_to_flag_copy <= '0;
		ptr_load <= '0;
		stk_op <= cfs_pkg::STK_NONE;
		#1;
	endtask : go
	task rd(input logic [5:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= '1;
		go();
		chk("rdata", 16'(e), 16'(reg_rdata));
	endtask : rd
	task wr(input logic [5:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= '1;
		go();
	endtask : wr
	////////////////////////////////////////
	task t_regs;
		chk("flags", 16'h0000, 16'(cpu_condition_flags));
		rd(cfs_pkg::STACK_POINTER_LOW_OFS, cfs_pkg::TOP_OF_DATA_MEMORY[7:0]);
		rd(cfs_pkg::STACK_POINTER_HIGH_OFS, cfs_pkg::TOP_OF_DATA_MEMORY[15:8]);
		rd(6'h00, 8'h00);
		wr(cfs_pkg::STACK_POINTER_HIGH_OFS, 8'h02);
		wr(cfs_pkg::STACK_POINTER_LOW_OFS, 8'h40);
		rd(cfs_pkg::STACK_POINTER_HIGH_OFS, 8'h02);
	endtask : t_regs
	task automatic t_stack;
		cfs_pkg::cfs_stk_op_t op [6] = '{cfs_pkg::STK_PUSH, cfs_pkg::STK_CALL, cfs_pkg::STK_POP,
			cfs_pkg::STK_RET, cfs_pkg::STK_INT, cfs_pkg::STK_INTERRUPT_EXIT};
		logic [15:0] sp [6] = '{16'h023f, 16'h023d, 16'h023e, 16'h0240, 16'h023e, 16'h0240};
		for (int i = 0; i < 6; i++) begin
			stk_op <= op[i];
			go();
			chk("sp", sp[i], stack_pointer);
		end
		chk("ret addr", 16'h023f, stk_addr);
		chk("flags", 16'h0080, 16'(cpu_condition_flags));
	endtask : t_stack
	task t_irq;
		irq_request <= '1;
		#1 chk("take", 16'h0001, 16'(irq_take));
		go();
		irq_request <= '0;
		chk("flags", 16'h0000, 16'(cpu_condition_flags));
		interrupt_enable_op <= '1;
		go();
		chk("flags", 16'h0080, 16'(cpu_condition_flags));
		interrupt_disable_op <= '1;
		go();
		irq_request <= '1;
		#1 chk("take", 16'h0000, 16'(irq_take));
		irq_request <= '0;
	endtask : t_irq
	task t_alu;
		alu_result <= 8'h80;
		alu_overflow <= '1;
		alu_carry <= '1;
		alu_half_en <= '1;
		alu_half_carry <= '1;
		alu_valid <= '1;
		go();
		chk("flags", 16'h002d, 16'(cpu_condition_flags));
		alu_result <= 8'h00;
		alu_carry <= '0;
		alu_half_en <= '0;
		alu_half_carry <= '0;
		alu_valid <= '1;
		go();
		chk("flags", 16'h003a, 16'(cpu_condition_flags));
		copy_bit_in <= '1;
		register_to_flag_copy <= '1;
		go();
		chk("flags", 16'h007a, 16'(cpu_condition_flags));
		chk("copy", 16'h0001, 16'(flag_to_register_copy_bit));
		rd(cfs_pkg::CPU_CONDITION_FLAGS_OFS, 8'h7a);
	endtask : t_alu
	task t_ptr;
		ptr_sel <= 2'h0;
		ptr_load_value <= 16'h0100;
		ptr_load <= '1;
		go();
		ptr_mode <= cfs_pkg::PTR_POSTINC;
		go();
		chk("ptr addr", 16'h0100, ptr_addr);
		ptr_mode <= cfs_pkg::PTR_PREDEC;
		go();
		chk("ptr addr", 16'h0100, ptr_addr);
		ptr_mode <= cfs_pkg::PTR_DISP;
		ptr_disp <= 6'h05;
		go();
		chk("ptr addr", 16'h0105, ptr_addr);
		ptr_mode <= cfs_pkg::PTR_NONE;
		ptr_sel <= 2'h2;
		go();
		chk("ptr addr", 16'h0000, ptr_addr);
		ptr_sel <= 2'h3;
	endtask : t_ptr
	////////////////////////////////////////
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 200) begin
			mismatches++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= '0;
		go();
		t_regs();
		t_stack();
		t_irq();
		t_alu();
		t_ptr();
		close_out();
	end
endmodule : testbench
